// ### logic/zeab_regs.svh
// Register indices, field positions and reset values of the zoned bus port.
// Assumes an includer that turns the indices into byte addresses itself.
`ifndef ZEAB_REGS_SVH
`define ZEAB_REGS_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define ZEAB_IDX_ZONE0_TIMING  16'h0B20
`define ZEAB_IDX_RSVD_TM_LO    16'h0B22
`define ZEAB_IDX_RSVD_TM_HI    16'h0B2A
`define ZEAB_IDX_ZONE6_TIMING  16'h0B2C
`define ZEAB_IDX_ZONE7_TIMING  16'h0B2E
`define ZEAB_IDX_RSVD_CFG1     16'h0B32
`define ZEAB_IDX_BUS_CFG       16'h0B34
`define ZEAB_IDX_BANK_CTRL     16'h0B38
`define ZEAB_IDX_MOD_REV       16'h0B3A
`define ZEAB_IDX_SOFT_RESET    16'h083D

// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define ZEAB_TM_SETUP_LSB      0
`define ZEAB_TM_ACTIVE_LSB     4
`define ZEAB_TM_HOLD_LSB       8
`define ZEAB_TM_FIELD_W        4
`define ZEAB_TM_RESET          32'h00000FFF
`define ZEAB_CFG_WIDE_BIT      0
`define ZEAB_CFG_BUSY_BIT      16
`define ZEAB_BANK_ZONE_LSB     0
`define ZEAB_BANK_CYC_LSB      3
`define ZEAB_BANK_RESET_ZONE   3'h7
`define ZEAB_BANK_RESET_CYC    3'h0
`define ZEAB_SRST_BIT          0
`define ZEAB_ZONE_A            3'h0
`define ZEAB_ZONE_B            3'h6
`define ZEAB_ZONE_C            3'h7

`endif

// ### logic/zeab_pkg.sv
// Types shared by the zoned bus port modules.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package zeab_pkg;
  // --------------------------------------------------------------------------
  // Access sequencer states
  // --------------------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE   = 5'h01,
    ST_GAP    = 5'h02,
    ST_SETUP  = 5'h04,
    ST_ACTIVE = 5'h08,
    ST_HOLD   = 5'h10
  } zeab_state_e;

  // State of one zone timing register
  typedef struct packed {
    logic [31:0] value;
  } zeab_treg_s;
endpackage

`default_nettype wire

// ### logic/zeab_zone_decode.sv
// Zone number to chip-select index decoder.
// Assumes a three-bit zone number from the requester; purely combinational.
`default_nettype none
`include "zeab_regs.svh"

module zeab_zone_decode (
  input  wire logic [2:0] i_zone,   // Zone number of the request
  output logic      [1:0] o_idx,    // Chip-select index 0..2
  output logic            o_valid   // Zone is implemented
);
  // Fixed zones always decode, the rest are reserved
  always_comb begin
    o_idx   = 2'h0;
    o_valid = 1'b0;
    unique case (i_zone)
      `ZEAB_ZONE_A: begin
        o_idx   = 2'h0;
        o_valid = 1'b1;
      end
      `ZEAB_ZONE_B: begin
        o_idx   = 2'h1;
        o_valid = 1'b1;
      end
      `ZEAB_ZONE_C: begin
        o_idx   = 2'h2;
        o_valid = 1'b1;
      end
      default: begin
        o_idx   = 2'h0;
        o_valid = 1'b0;
      end
    endcase
  end
endmodule

`default_nettype wire

// ### logic/zeab_zone_timing.sv
// One zone timing register with write and soft clear.
// Assumes one-cycle write and clear strobes from the register port.
`default_nettype none

module zeab_zone_timing #(
  parameter logic [31:0] RESET_VAL = 32'h00000FFF
) (
  input  wire logic        i_ref_clk,  // Clock
  input  wire logic        i_resetn,   // Async reset, low
  input  wire logic        i_wr,       // Write strobe
  input  wire logic [31:0] i_wdata,    // Write data
  input  wire logic        i_clear,    // Soft reset to default
  output logic      [31:0] o_value     // Current timing word
);
  zeab_pkg::zeab_treg_s r_ff;
  zeab_pkg::zeab_treg_s nxt_r;

  // Clear wins over a write in the same cycle
  always_comb begin
    nxt_r = r_ff;
    if (i_clear) begin
      nxt_r.value = RESET_VAL;
    end else if (i_wr) begin
      nxt_r.value = i_wdata;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      r_ff.value <= RESET_VAL;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign o_value = r_ff.value;
endmodule

`default_nettype wire

// ### logic/zeab_bus.sv
// Zoned external asynchronous bus port: register file and access sequencer.
// Assumes one requester that waits for o_req_ready and a register master
// with single-cycle strobes; the external parts need no clock.
//
// The address-and-strobe port was left to the implementer.
`default_nettype none
`include "zeab_regs.svh"

module zeab_bus #(
  parameter int          ADDR_W  = 20,
  parameter logic [15:0] REV_ID  = 16'h0A5C   // Arbitrary revision value
) (
  input  wire logic              i_ref_clk,    // 40 MHz clock
  input  wire logic              i_resetn,     // Async reset, low
  input  wire logic [15:0]       i_reg_addr,   // Register byte address
  input  wire logic [31:0]       i_reg_wdata,  // Register write data
  input  wire logic              i_reg_wr,     // Register write strobe
  input  wire logic              i_reg_rd,     // Register read strobe
  output logic      [31:0]       o_reg_rdata,  // Read data, cycle after strobe
  input  wire logic              i_req,        // Access request
  input  wire logic              i_req_we,     // 1 write, 0 read
  input  wire logic [2:0]        i_req_zone,   // Target zone number
  input  wire logic [ADDR_W-1:0] i_req_addr,   // Address within zone
  input  wire logic [31:0]       i_req_wdata,  // Write data
  input  wire logic [1:0]        i_req_hwen,   // Half-word enables, wide mode
  output logic                   o_req_ready,  // Request can be taken
  output logic                   o_rsp_valid,  // Access done pulse
  output logic                   o_rsp_err,    // Reserved zone or abort
  output logic      [31:0]       o_rsp_rdata,  // Read data of last read access
  output logic [ADDR_W-1:1]      o_xa,         // Address pins above bit 0
  output logic                   o_a0_we1,     // Address bit 0 or upper strobe
  output logic                   o_we0_n,      // Write strobe, low half
  output logic                   o_rd_n,       // Read strobe
  output logic      [2:0]        o_cs_n,       // Selects for zones 0, 6, 7
  output logic      [31:0]       o_xd_out,     // Data pins, driven value
  output logic                   o_xd_oe,      // Data pins driven
  input  wire logic [31:0]       i_xd_in       // Data pins, sampled value
);
  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef struct packed {
    zeab_pkg::zeab_state_e state;
    logic [`ZEAB_TM_FIELD_W-1:0] cnt;
    logic [1:0]        idx;
    logic [2:0]        zone;
    logic [2:0]        last_zone;
    logic              last_valid;
    logic              we;
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
    logic [1:0]        hwen;
    logic [31:0]       tm;
    logic              cfg_wide;
    logic [2:0]        bank_zone;
    logic [2:0]        bank_cyc;
    logic              srst;
    logic [2:0]        cs_n;
    logic              rd_n;
    logic              we0_n;
    logic              a0_we1;
    logic [31:0]       xd_out;
    logic              xd_oe;
    logic              req_ready;
    logic              rsp_valid;
    logic              rsp_err;
    logic [31:0]       rsp_rdata;
    logic [31:0]       reg_rdata;
  } zeab_core_s;

  zeab_core_s r_ff;
  zeab_core_s nxt_r;

  localparam int NZ = 3;
  localparam logic [15:0] TM_IDX [NZ] = '{`ZEAB_IDX_ZONE0_TIMING, `ZEAB_IDX_ZONE6_TIMING,
                                          `ZEAB_IDX_ZONE7_TIMING};

  function automatic logic [15:0] byte_of(input logic [15:0] idx);
    return {idx[13:0], 2'b00};
  endfunction

  logic [31:0] tm_val [NZ];
  logic [1:0]  dec_idx;
  logic        dec_valid;
  logic [31:0] tm_sel;
  logic        acc_on;
  logic        cs_on;

  // --------------------------------------------------------------------------
  // Zone decode and per-zone timing registers
  // --------------------------------------------------------------------------
  zeab_zone_decode u_decode (
    .i_zone  (i_req_zone),
    .o_idx   (dec_idx),
    .o_valid (dec_valid)
  );

  // One timing register per implemented zone only
  for (genvar g = 0; g < NZ; g++) begin : g_tm
    zeab_zone_timing #(
      .RESET_VAL (`ZEAB_TM_RESET)
    ) u_tm (
      .i_ref_clk (i_ref_clk),
      .i_resetn  (i_resetn),
      .i_wr      (i_reg_wr && (i_reg_addr == byte_of(TM_IDX[g]))),
      .i_wdata   (i_reg_wdata),
      .i_clear   (r_ff.srst),
      .o_value   (tm_val[g])
    );
  end

  // Timing word of the targeted zone
  always_comb begin
    tm_sel = tm_val[0];
    if (dec_idx == 2'h1) begin
      tm_sel = tm_val[1];
    end else if (dec_idx == 2'h2) begin
      tm_sel = tm_val[2];
    end
  end

  // --------------------------------------------------------------------------
  // Next state: registers, sequencer, pins
  // --------------------------------------------------------------------------
  always_comb begin
    nxt_r           = r_ff;
    nxt_r.rsp_valid = 1'b0;
    nxt_r.rsp_err   = 1'b0;
    nxt_r.srst      = 1'b0;
    nxt_r.reg_rdata = 32'h00000000;
    acc_on          = 1'b0;
    cs_on           = 1'b0;
    // Register writes; reserved slots ignore writes
    if (i_reg_wr) begin
      if (i_reg_addr == byte_of(`ZEAB_IDX_BUS_CFG)) begin
        nxt_r.cfg_wide = i_reg_wdata[`ZEAB_CFG_WIDE_BIT];
      end
      if (i_reg_addr == byte_of(`ZEAB_IDX_BANK_CTRL)) begin
        nxt_r.bank_zone = i_reg_wdata[`ZEAB_BANK_ZONE_LSB +: 3];
        nxt_r.bank_cyc  = i_reg_wdata[`ZEAB_BANK_CYC_LSB +: 3];
      end
      if (i_reg_addr == byte_of(`ZEAB_IDX_SOFT_RESET)) begin
        nxt_r.srst = i_reg_wdata[`ZEAB_SRST_BIT];
      end
    end
    // Register reads; unmapped and reserved read zero
    if (i_reg_rd) begin
      for (int k = 0; k < NZ; k++) begin
        if (i_reg_addr == byte_of(TM_IDX[k])) begin
          nxt_r.reg_rdata = tm_val[k];
        end
      end
      if (i_reg_addr == byte_of(`ZEAB_IDX_BUS_CFG)) begin
        nxt_r.reg_rdata[`ZEAB_CFG_WIDE_BIT] = r_ff.cfg_wide;
        nxt_r.reg_rdata[`ZEAB_CFG_BUSY_BIT] = (r_ff.state != zeab_pkg::ST_IDLE);
      end
      if (i_reg_addr == byte_of(`ZEAB_IDX_BANK_CTRL)) begin
        nxt_r.reg_rdata[`ZEAB_BANK_ZONE_LSB +: 3] = r_ff.bank_zone;
        nxt_r.reg_rdata[`ZEAB_BANK_CYC_LSB +: 3]  = r_ff.bank_cyc;
      end
      if (i_reg_addr == byte_of(`ZEAB_IDX_MOD_REV)) begin
        nxt_r.reg_rdata[15:0] = REV_ID;
      end
    end
    // Access sequencer
    unique case (r_ff.state)
      zeab_pkg::ST_IDLE: begin
        if (i_req && r_ff.req_ready) begin
          if (!dec_valid) begin
            // Reserved zone answered at once, no select
            nxt_r.rsp_valid = 1'b1;
            nxt_r.rsp_err   = 1'b1;
          end else begin
            // Zones 0, 6, 7 need no enabling step
            nxt_r.idx   = dec_idx;
            nxt_r.zone  = i_req_zone;
            nxt_r.we    = i_req_we;
            nxt_r.addr  = i_req_addr;
            nxt_r.wdata = i_req_wdata;
            nxt_r.hwen  = i_req_hwen;
            nxt_r.tm    = tm_sel;
            if (r_ff.last_valid && (r_ff.last_zone != i_req_zone) && (r_ff.bank_cyc != 3'h0)
                && ((r_ff.last_zone == r_ff.bank_zone) || (i_req_zone == r_ff.bank_zone))) begin
              nxt_r.state = zeab_pkg::ST_GAP;
              nxt_r.cnt   = {1'b0, r_ff.bank_cyc} - 4'h1;
            end else begin
              nxt_r.state = zeab_pkg::ST_SETUP;
              nxt_r.cnt   = tm_sel[`ZEAB_TM_SETUP_LSB +: `ZEAB_TM_FIELD_W];
            end
          end
        end
      end
      zeab_pkg::ST_GAP: begin
        if (r_ff.cnt == 4'h0) begin
          nxt_r.state = zeab_pkg::ST_SETUP;
          nxt_r.cnt   = r_ff.tm[`ZEAB_TM_SETUP_LSB +: `ZEAB_TM_FIELD_W];
        end else begin
          nxt_r.cnt = r_ff.cnt - 4'h1;
        end
      end
      zeab_pkg::ST_SETUP: begin
        if (r_ff.cnt == 4'h0) begin
          nxt_r.state = zeab_pkg::ST_ACTIVE;
          nxt_r.cnt   = r_ff.tm[`ZEAB_TM_ACTIVE_LSB +: `ZEAB_TM_FIELD_W];
        end else begin
          nxt_r.cnt = r_ff.cnt - 4'h1;
        end
      end
      zeab_pkg::ST_ACTIVE: begin
        if (r_ff.cnt == 4'h0) begin
          nxt_r.state = zeab_pkg::ST_HOLD;
          nxt_r.cnt   = r_ff.tm[`ZEAB_TM_HOLD_LSB +: `ZEAB_TM_FIELD_W];
          if (!r_ff.we) begin
            nxt_r.rsp_rdata = r_ff.cfg_wide ? i_xd_in : {16'h0000, i_xd_in[15:0]};
          end
        end else begin
          nxt_r.cnt = r_ff.cnt - 4'h1;
        end
      end
      zeab_pkg::ST_HOLD: begin
        if (r_ff.cnt == 4'h0) begin
          nxt_r.state      = zeab_pkg::ST_IDLE;
          nxt_r.rsp_valid  = 1'b1;
          nxt_r.last_zone  = r_ff.zone;
          nxt_r.last_valid = 1'b1;
        end else begin
          nxt_r.cnt = r_ff.cnt - 4'h1;
        end
      end
      default: begin
        nxt_r.state = zeab_pkg::ST_IDLE;
      end
    endcase
    // Soft reset aborts an access and restores configuration
    if (nxt_r.srst) begin
      if (r_ff.state != zeab_pkg::ST_IDLE) begin
        nxt_r.rsp_valid = 1'b1;
        nxt_r.rsp_err   = 1'b1;
      end
      nxt_r.state      = zeab_pkg::ST_IDLE;
      nxt_r.cfg_wide   = 1'b0;
      nxt_r.bank_zone  = `ZEAB_BANK_RESET_ZONE;
      nxt_r.bank_cyc   = `ZEAB_BANK_RESET_CYC;
      nxt_r.last_valid = 1'b0;
    end
    nxt_r.req_ready = (nxt_r.state == zeab_pkg::ST_IDLE);
    // Pins follow the next state, so they leave the flops with it
    acc_on = (nxt_r.state == zeab_pkg::ST_ACTIVE);
    cs_on  = (nxt_r.state == zeab_pkg::ST_SETUP) || acc_on || (nxt_r.state == zeab_pkg::ST_HOLD);
    nxt_r.cs_n = 3'h7;
    if (cs_on) begin
      nxt_r.cs_n[nxt_r.idx] = 1'b0;
    end
    nxt_r.rd_n = !(acc_on && !nxt_r.we);
    if (nxt_r.cfg_wide) begin
      nxt_r.we0_n  = !(acc_on && nxt_r.we && nxt_r.hwen[0]);
      nxt_r.a0_we1 = !(acc_on && nxt_r.we && nxt_r.hwen[1]);
      nxt_r.xd_out = nxt_r.wdata;
    end else begin
      nxt_r.we0_n  = !(acc_on && nxt_r.we);
      nxt_r.a0_we1 = nxt_r.addr[0];
      nxt_r.xd_out = {16'h0000, nxt_r.wdata[15:0]};
    end
    nxt_r.xd_oe = cs_on && nxt_r.we;
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      r_ff           <= '0;
      r_ff.state     <= zeab_pkg::ST_IDLE;
      r_ff.bank_zone <= `ZEAB_BANK_RESET_ZONE;
      r_ff.bank_cyc  <= `ZEAB_BANK_RESET_CYC;
      r_ff.cs_n      <= 3'h7;
      r_ff.rd_n      <= 1'b1;
      r_ff.we0_n     <= 1'b1;
      r_ff.req_ready <= 1'b1;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // Outputs straight from the state flops
  assign o_reg_rdata = r_ff.reg_rdata;
  assign o_req_ready = r_ff.req_ready;
  assign o_rsp_valid = r_ff.rsp_valid;
  assign o_rsp_err   = r_ff.rsp_err;
  assign o_rsp_rdata = r_ff.rsp_rdata;
  assign o_xa        = r_ff.addr[ADDR_W-1:1];
  assign o_a0_we1    = r_ff.a0_we1;
  assign o_we0_n     = r_ff.we0_n;
  assign o_rd_n      = r_ff.rd_n;
  assign o_cs_n      = r_ff.cs_n;
  assign o_xd_out    = r_ff.xd_out;
  assign o_xd_oe     = r_ff.xd_oe;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  logic [4:0] act_len_ff;

  // Cycles spent so far in the strobe phase
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      act_len_ff <= 5'h00;
    end else begin
      act_len_ff <= (r_ff.state == zeab_pkg::ST_ACTIVE) ? act_len_ff + 5'h01 : 5'h00;
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);

  sequence s_take_zone0;
    i_req && o_req_ready && dec_valid && (i_req_zone == `ZEAB_ZONE_A);
  endsequence
  sequence s_cs0_low;
    ##[1:9] !o_cs_n[0];
  endsequence

  a_strobe_in_select: assert property ((!o_rd_n || !o_we0_n) |-> !(&o_cs_n))
    else $error("strobe low without a select");
  a_zone0_select: assert property (s_take_zone0 |-> s_cs0_low)
    else $error("zone 0 select missing");
  a_wait_length: assert property ((r_ff.state == zeab_pkg::ST_ACTIVE && r_ff.cnt == 4'h0)
      |-> act_len_ff == {1'b0, r_ff.tm[`ZEAB_TM_ACTIVE_LSB +: `ZEAB_TM_FIELD_W]})
    else $error("strobe phase length wrong");
  a_one_select: assert property ($onehot0(~o_cs_n))
    else $error("more than one select low");
  a_reserved_zone: assert property ((i_req && o_req_ready && !dec_valid)
      |=> (o_rsp_valid && o_rsp_err && (&o_cs_n)))
    else $error("reserved zone not refused");
  a_narrow_addr0: assert property ((!(&o_cs_n) && !r_ff.cfg_wide) |-> o_a0_we1 == r_ff.addr[0])
    else $error("address bit 0 wrong");
  a_wide_upper_we: assert property ((r_ff.cfg_wide && !o_cs_n[r_ff.idx] && r_ff.we && r_ff.hwen[1]
      && r_ff.state == zeab_pkg::ST_ACTIVE) |-> !o_a0_we1)
    else $error("upper write strobe missing");
  a_rsvd_cfg_zero: assert property ((i_reg_rd && i_reg_addr == byte_of(`ZEAB_IDX_RSVD_CFG1))
      |=> o_reg_rdata == 32'h00000000)
    else $error("reserved slot reads nonzero");
  a_idle_pins_high: assert property ((r_ff.state == zeab_pkg::ST_IDLE)
      |-> ((&o_cs_n) && o_rd_n && o_we0_n && !o_xd_oe))
    else $error("pins active while idle");
endmodule

`default_nettype wire

// ### verification/zeab_ext_mem.sv
// Behavioural asynchronous memory hung on the zoned bus pins.
// Assumes active-low selects and strobes; it needs no clock of its own.
`default_nettype none

module zeab_ext_mem (
  input  wire logic [19:1] i_xa,     // Address pins above bit 0
  input  wire logic        i_we0_n,  // Write strobe
  input  wire logic        i_a0_we1, // Upper write strobe, wide mode
  input  wire logic        i_rd_n,   // Read strobe
  input  wire logic [2:0]  i_cs_n,   // Zone selects
  input  wire logic [31:0] i_xd,     // Data driven by the port
  input  wire logic        i_xd_oe,  // Port drives data
  output logic      [31:0] o_xd      // Data seen by the port
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [31:0] mem [0:47];
  logic [31:0] last = 32'h00000000;
  logic [5:0]  idx;
  logic        sel;

  // ---------------------------------------------------------------------------
  // Decode and storage
  // ---------------------------------------------------------------------------
  // One bank of words for each select line
  assign sel = (i_cs_n != 3'h7);
  assign idx = {(i_cs_n[0] == 1'b0) ? 2'h0 : (i_cs_n[1] == 1'b0) ? 2'h1 : 2'h2, i_xa[4:1]};

  // Lower half lands on the strobe's rising edge, no clock involved
  always @(posedge i_we0_n) begin
    if (sel && i_xd_oe) begin
      mem[idx][15:0] <= i_xd[15:0];
    end
  end

  // Upper half; in 16-bit mode only zeros land, narrow reads ignore them
  always @(posedge i_a0_we1) begin
    if (sel && i_xd_oe) begin
      mem[idx][31:16] <= i_xd[31:16];
    end
  end

  // Remember what was driven so a released bus shows its inverse
  always @(posedge i_rd_n) begin
    last <= mem[idx];
  end

  // Data only while selected and read strobe low
  assign o_xd = (sel && !i_rd_n) ? mem[idx] : ~last;
endmodule

`default_nettype wire

// ### verification/testbench.sv
// Self-checking bench of the zoned bus port: register port and accesses.
// Assumes the port design and the memory model compiled beforehand.
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [15:0] REV = 16'h3C1E; // Arbitrary revision value
  localparam logic [15:0] RA [0:8] = '{16'h2C80, 16'h2CB0, 16'h2CB8, 16'h2CD0, 16'h2CE0,
                                       16'h2CE8, 16'h2C88, 16'h2CC8, 16'h2DFC};
  localparam logic [31:0] RV [0:8] = '{32'hFFF, 32'hFFF, 32'hFFF, 32'h0, 32'h7,
                                       {16'h0, REV}, 32'h0, 32'h0, 32'h0};
  localparam logic [31:0] TM [0:2] = '{32'h00000010, 32'h00000132, 32'h00000201};
  localparam logic [2:0]  ZN [0:2] = '{3'h0, 3'h6, 3'h7};

  logic        i_ref_clk, i_resetn, i_reg_wr, i_reg_rd, i_req, i_req_we;
  logic [15:0] i_reg_addr;
  logic [31:0] i_reg_wdata, i_req_wdata, o_reg_rdata, o_rsp_rdata, o_xd_out, i_xd_in, d;
  logic [2:0]  i_req_zone, o_cs_n, seen;
  logic [19:0] i_req_addr;
  logic [19:1] o_xa;
  logic [1:0]  i_req_hwen;
  logic        o_req_ready, o_rsp_valid, o_rsp_err, o_a0_we1, o_we0_n, o_rd_n, o_xd_oe, err;
  int          err_count, checks_done, cyc, strb, a0lo, ex;

  // ---------------------------------------------------------------------------
  // Design and far side
  // ---------------------------------------------------------------------------
  zeab_bus #(.ADDR_W(20), .REV_ID(REV)) u_zeab_bus (
    .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .i_req(i_req),
    .i_req_we(i_req_we), .i_req_zone(i_req_zone), .i_req_addr(i_req_addr), .i_req_wdata(i_req_wdata),
    .i_req_hwen(i_req_hwen), .o_req_ready(o_req_ready), .o_rsp_valid(o_rsp_valid), .o_rsp_err(o_rsp_err),
    .o_rsp_rdata(o_rsp_rdata), .o_xa(o_xa), .o_a0_we1(o_a0_we1), .o_we0_n(o_we0_n), .o_rd_n(o_rd_n),
    .o_cs_n(o_cs_n), .o_xd_out(o_xd_out), .o_xd_oe(o_xd_oe), .i_xd_in(i_xd_in));

  zeab_ext_mem u_zeab_ext_mem (
    .i_xa(o_xa), .i_we0_n(o_we0_n), .i_a0_we1(o_a0_we1), .i_rd_n(o_rd_n), .i_cs_n(o_cs_n), .i_xd(o_xd_out),
    .i_xd_oe(o_xd_oe), .o_xd(i_xd_in));

  // Clock, 25 ns period
  initial begin
    i_ref_clk = 1'b0;
    forever #12.5 i_ref_clk = ~i_ref_clk;
  end

  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  // Compare and count
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  // Verdict and end of run
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // One-cycle register write
  task automatic wr(input logic [15:0] a, input logic [31:0] v);
    @(posedge i_ref_clk);
    i_reg_wr    <= 1'b1;
    i_reg_addr  <= a;
    i_reg_wdata <= v;
    @(posedge i_ref_clk);
    i_reg_wr <= 1'b0;
  endtask

  // One-cycle register read, data in the following cycle
  task automatic rd(input logic [15:0] a, output logic [31:0] v);
    @(posedge i_ref_clk);
    i_reg_rd   <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_ref_clk);
    i_reg_rd <= 1'b0;
    #1;
    v = o_reg_rdata;
  endtask

  // One access; records length, selects seen, strobe and a0 low cycles
  task automatic acc(input logic we, input logic [2:0] z, input logic [19:0] a, input logic [31:0] w,
                     input logic [1:0] h);
    @(posedge i_ref_clk);
    i_req       <= 1'b1;
    i_req_we    <= we;
    i_req_zone  <= z;
    i_req_addr  <= a;
    i_req_wdata <= w;
    i_req_hwen  <= h;
    @(posedge i_ref_clk);
    i_req <= 1'b0;
    cyc  = 0;
    seen = 3'h0;
    strb = 0;
    a0lo = 0;
    while (cyc < 60) begin
      #1;
      cyc++;
      seen = seen | ~o_cs_n;
      if ((we ? o_we0_n : o_rd_n) === 1'b0) strb++;
      if (o_a0_we1 === 1'b0) a0lo++;
      if (o_rsp_valid === 1'b1) break;
      @(posedge i_ref_clk);
    end
    err = o_rsp_err;
    d   = o_rsp_rdata;
    @(posedge i_ref_clk);
    #1;
    chk(32'({o_cs_n, o_rd_n, o_we0_n, o_req_ready}), 32'h3F);
  endtask

  // ---------------------------------------------------------------------------
  // Watchdog
  // ---------------------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge i_ref_clk);
    err_count++;
    close_out();
  end

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    {i_resetn, i_reg_wr, i_reg_rd, i_req, i_req_we} = 5'h00;
    {i_reg_addr, i_reg_wdata, i_req_wdata} = 80'h0;
    {i_req_zone, i_req_addr, i_req_hwen} = 25'h0;
    err_count   = 0;
    checks_done = 0;
    repeat (16) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    // Reset values, reserved and unmapped places
    for (int k = 0; k < 9; k++) begin
      rd(RA[k], d);
      chk(d, RV[k]);
    end
    // Writes to read-only, reserved and unmapped places change nothing
    for (int k = 5; k < 9; k++) begin
      wr(RA[k], 32'hFFFFFFFF);
      rd(RA[k], d);
      chk(d, RV[k]);
    end
    // Each zone with its own timing, 16-bit bus
    for (int i = 0; i < 3; i++) begin
      wr(RA[i], TM[i]);
      rd(RA[i], d);
      chk(d, TM[i]);
    end
    for (int i = 0; i < 3; i++) begin
      ex = TM[i][3:0] + TM[i][7:4] + TM[i][11:8] + 4;
      acc(1'b1, ZN[i], 20'h00004, 32'h5A5A1230 + i, 2'h3);
      chk(32'(cyc), 32'(ex));
      chk(32'(seen), 32'(3'h1 << i));
      chk(32'(strb), 32'(TM[i][7:4] + 1));
      chk(32'(a0lo), 32'(cyc));
      acc(1'b0, ZN[i], 20'h00004, 32'h0, 2'h3);
      chk(d, {16'h0, 16'h1230 + 16'(i)});
      chk(32'(seen), 32'(3'h1 << i));
      chk(32'({err, strb[3:0]}), 32'(TM[i][7:4] + 1));
    end
    // Reserved zones answer with an error and no select
    for (int z = 1; z < 6; z++) begin
      acc(1'b0, 3'(z), 20'h00004, 32'h0, 2'h3);
      chk(32'({err, seen, cyc[3:0]}), 32'h81);
    end
    // Shared pin carries address bit 0 in 16-bit mode
    acc(1'b1, 3'h0, 20'h00005, 32'h00001111, 2'h3);
    chk(32'(a0lo), 32'h0);
    // Shared pin becomes upper write strobe in 32-bit mode
    wr(16'h2CD0, 32'h1);
    acc(1'b1, 3'h0, 20'h00008, 32'hCAFE8421, 2'h3);
    chk(32'(a0lo), 32'(TM[0][7:4] + 1));
    acc(1'b0, 3'h0, 20'h00008, 32'h0, 2'h3);
    chk(d, 32'hCAFE8421);
    acc(1'b1, 3'h0, 20'h00008, 32'h00007777, 2'h1);
    chk(32'(a0lo), 32'h0);
    acc(1'b0, 3'h0, 20'h00008, 32'h0, 2'h3);
    chk(d, 32'hCAFE7777);
    // Idle gap of two cycles when leaving the bank zone
    wr(16'h2CE0, 32'h10);
    acc(1'b0, 3'h6, 20'h00004, 32'h0, 2'h3);
    chk(32'(cyc), 32'h0C);
    // Soft reset returns configuration, bank and timing to defaults
    wr(16'h20F4, 32'h1);
    repeat (3) @(posedge i_ref_clk);
    for (int k = 0; k < 5; k++) begin
      rd(RA[k], d);
      chk(d, RV[k]);
    end
    // Busy while an access runs; soft reset aborts it with an error
    @(posedge i_ref_clk);
    i_req      <= 1'b1;
    i_req_we   <= 1'b0;
    i_req_zone <= 3'h7;
    @(posedge i_ref_clk);
    i_req <= 1'b0;
    rd(16'h2CD0, d);
    chk(d, 32'h00010000);
    wr(16'h20F4, 32'h1);
    #1;
    chk(32'({o_rsp_valid, o_rsp_err, o_cs_n}), 32'h1F);
    close_out();
  end
endmodule

`default_nettype wire
